// ### hw/eeprom_ctrl_pkg.sv
// constants and types for the nonvolatile programming and protection block
// assumes an APB master with 32-bit data and a 40 MHz E clock on pclk
//
// Overview of operation
// - An erased cell reads 1, programming a 1 changes nothing, a 0 sticks.
// - With latch-select clear the array reads like plain read-only memory.
// - The control register is always readable and writable, yet cells change only by the sequence.
// - A section or the config cell changes only while its protect bit is clear.
// - The pump runs on the E clock when its select bit is 0 and on the RC clock when it is 1.
// - High voltage needs latch-select write, then a data write, then latch-select plus voltage enable.
// - One write setting latch-select and voltage enable together leaves both clear.
// - All active protect bits reset to 1.
// - In normal modes protect bits clear only within 64 E clocks of reset.
// - Writing 1 to a protect bit always protects again, in every mode.
// - In special modes the protect register may be written any number of times.
// - The array is mapped only while the array-visible config bit is set.
// - Mode pin B high at reset gives a normal mode, low a special mode.
// - On reset release the special flag loads not-B and the select-A flag loads A.
// - The special flag never sets again once clear; select-A is write-once in normal modes.
package eeprom_ctrl_pkg;

  localparam int ADDR_W = 13;

  // register byte offsets
  localparam logic [12:0] OFF_PROG = 13'h0000;
  localparam logic [12:0] OFF_BLOCK_PROTECT_REG = 13'h0004;
  localparam logic [12:0] OFF_OPTION = 13'h0008;
  localparam logic [12:0] OFF_CONFIG = 13'h000C;
  localparam logic [12:0] OFF_MODE = 13'h0010;
  localparam logic [12:0] OFF_STATUS = 13'h0014;
  localparam logic [12:0] ARRAY_BASE = 13'h1000;
  localparam logic [12:0] CFG_CELL_ADDR = 13'h0018;

  // control register fields
  localparam int PROG_VOLT = 0;
  localparam int PROG_LATCH = 1;
  localparam int PROG_ERASE = 2;

  // option, config and mode fields
  localparam int OPT_PUMP_SEL = 0;
  localparam int CFG_VISIBLE = 0;
  localparam int MODE_SEL_A = 0;
  localparam int MODE_SPECIAL = 1;

  // status fields
  localparam int STAT_WINDOW = 0;
  localparam int STAT_VOLT = 1;
  localparam int STAT_LOADED = 2;

  localparam int DATA_W = 8;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [7:0] CFG_RESET = 8'hFF;

  // clearing window, in E clock cycles
  localparam int UNLOCK_CYCLES = 64;
  localparam int CNT_W = 7;

  typedef enum
  {
    SEQ_IDLE,
    SEQ_ARMED,
    SEQ_LOADED,
    SEQ_HIGHV
  } seq_state_t;

endpackage

// ### hw/eeprom_program_protect_ctrl.sv
// nonvolatile array controller: program sequence, protection, mode latch
// assumes an APB master; pins mode_pin_a/b are stable across reset release
//
// Added by the designer: the register addresses and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module eeprom_program_protect_ctrl #(
  parameter int DEPTH = 512,
  parameter int NUM_SECT = 4
)(
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [12:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // mode pins
  input wire logic mode_pin_a,
  input wire logic mode_pin_b,
  // charge pump
  input wire logic rc_osc_clk,
  output logic pump_clk,
  output logic vpp_enable,
  // mode and map status
  output logic special_mode_flag,
  output logic mode_select_a_flag,
  output logic array_visible_enable
);

  localparam int AW = $clog2(DEPTH);
  localparam int SECT_W = $clog2(NUM_SECT);
  localparam int BP_W = NUM_SECT + 1;
  localparam int BP_CFG = NUM_SECT;
  localparam int CW = eeprom_ctrl_pkg::CNT_W;
  // refuse sizes that the index, section and window logic cannot serve
  if (DEPTH < 2 || (1 << AW) != DEPTH || DEPTH > 1024)
    $error("DEPTH must be a power of two from 2 to 1024");
  if (NUM_SECT < 2 || (1 << SECT_W) != NUM_SECT || NUM_SECT > DEPTH)
    $error("NUM_SECT must be a power of two from 2 to DEPTH");
  if ((1 << CW) <= eeprom_ctrl_pkg::UNLOCK_CYCLES)
    $error("window counter too narrow for the unlock span");
  // state
  eeprom_ctrl_pkg::seq_state_t seq_ff;
  logic volt_ff;
  logic latch_ff;
  logic erase_ff;
  logic apply_ff;
  logic lat_cfg_ff;
  logic [AW-1:0] lat_idx_ff;
  logic [7:0] lat_data_ff;
  logic [BP_W-1:0] block_protect_reg_ff;
  logic bp_written_ff;
  logic [CW-1:0] cnt_ff;
  logic pump_sel_ff;
  logic [7:0] cfg_ff;
  logic captured_ff;
  logic special_mode_flag_ff;
  logic mda_ff;
  logic mda_written_ff;
  logic [31:0] prdata_ff;

  // decode
  logic wr_acc;
  logic rd_setup;
  logic in_array;
  logic is_cfg_cell;
  logic hit;
  logic window_open;
  logic [AW-1:0] acc_idx;
  logic [7:0] arr_rd;
  logic data_wr;
  logic [BP_W-1:0] w_bp;
  logic [BP_W-1:0] nxt_block_protect_reg;
  // protect bit covering a byte of the array
  function automatic logic [SECT_W-1:0] sect_of(input logic [AW-1:0] idx);
    sect_of = idx[AW-1 -: SECT_W];
  endfunction
  // true when the addressed target may not be changed
  function automatic logic blocked(
    input logic [BP_W-1:0] bp,
    input logic cfg,
    input logic [AW-1:0] idx
  );
    if (cfg)
      blocked = bp[BP_CFG];
    else
      blocked = bp[sect_of(idx)];
  endfunction
  // array window test, used for reads and for latch writes
  function automatic logic array_hit(input logic [12:0] a, input logic vis);
    array_hit = vis && a[1:0] == 2'b00 &&
      a >= eeprom_ctrl_pkg::ARRAY_BASE &&
      (a - eeprom_ctrl_pkg::ARRAY_BASE) < 13'(DEPTH * 4);
  endfunction
  assign wr_acc = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign in_array = array_hit(paddr, cfg_ff[eeprom_ctrl_pkg::CFG_VISIBLE]);
  assign is_cfg_cell = paddr == eeprom_ctrl_pkg::CFG_CELL_ADDR;
  assign acc_idx = AW'((paddr - eeprom_ctrl_pkg::ARRAY_BASE) >> 2);
  assign window_open = cnt_ff < CW'(eeprom_ctrl_pkg::UNLOCK_CYCLES);
  assign w_bp = pwdata[BP_W-1:0];

  always_comb
  begin
    case (paddr)
      eeprom_ctrl_pkg::OFF_PROG,
      eeprom_ctrl_pkg::OFF_BLOCK_PROTECT_REG,
      eeprom_ctrl_pkg::OFF_OPTION,
      eeprom_ctrl_pkg::OFF_CONFIG,
      eeprom_ctrl_pkg::OFF_MODE,
      eeprom_ctrl_pkg::OFF_STATUS,
      eeprom_ctrl_pkg::CFG_CELL_ADDR: hit = 1'b1;
      default: hit = in_array;
    endcase
  end

  // zero wait states; reads are captured in the setup cycle
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;

  // data write to a cell while latching and the target is unprotected
  assign data_wr = wr_acc && (in_array || is_cfg_cell) &&
    (seq_ff == eeprom_ctrl_pkg::SEQ_ARMED ||
     seq_ff == eeprom_ctrl_pkg::SEQ_LOADED) &&
    !blocked(block_protect_reg_ff, is_cfg_cell, acc_idx);

  // program control register and sequence
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      seq_ff <= eeprom_ctrl_pkg::SEQ_IDLE;
      latch_ff <= 1'b0;
      volt_ff <= 1'b0;
      erase_ff <= 1'b0;
    end
    else if (wr_acc && paddr == eeprom_ctrl_pkg::OFF_PROG)
    begin
      if (!pwdata[eeprom_ctrl_pkg::PROG_LATCH])
      begin
        // leaving latch mode drops voltage and forgets the latched byte
        latch_ff <= 1'b0;
        volt_ff <= 1'b0;
        erase_ff <= pwdata[eeprom_ctrl_pkg::PROG_ERASE];
        seq_ff <= eeprom_ctrl_pkg::SEQ_IDLE;
      end
      else if (!latch_ff)
      begin
        if (pwdata[eeprom_ctrl_pkg::PROG_VOLT])
        begin
          latch_ff <= 1'b0;
          volt_ff <= 1'b0;
          seq_ff <= eeprom_ctrl_pkg::SEQ_IDLE;
        end
        else
        begin
          latch_ff <= 1'b1;
          erase_ff <= pwdata[eeprom_ctrl_pkg::PROG_ERASE];
          seq_ff <= eeprom_ctrl_pkg::SEQ_ARMED;
        end
      end
      else if (pwdata[eeprom_ctrl_pkg::PROG_VOLT])
      begin
        // voltage only after a latched, still unprotected target
        if (seq_ff == eeprom_ctrl_pkg::SEQ_LOADED &&
            !blocked(block_protect_reg_ff, lat_cfg_ff, lat_idx_ff))
        begin
          volt_ff <= 1'b1;
          seq_ff <= eeprom_ctrl_pkg::SEQ_HIGHV;
        end
        else if (seq_ff != eeprom_ctrl_pkg::SEQ_HIGHV)
          volt_ff <= 1'b0;
      end
      else
      begin
        volt_ff <= 1'b0;
        if (seq_ff == eeprom_ctrl_pkg::SEQ_HIGHV)
          seq_ff <= eeprom_ctrl_pkg::SEQ_LOADED;
        else
          erase_ff <= pwdata[eeprom_ctrl_pkg::PROG_ERASE];
      end
    end
    else if (data_wr)
      seq_ff <= eeprom_ctrl_pkg::SEQ_LOADED;
  end

  // latched target and data
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lat_cfg_ff <= 1'b0;
      lat_idx_ff <= '0;
      lat_data_ff <= eeprom_ctrl_pkg::ERASED_BYTE;
    end
    else if (data_wr)
    begin
      lat_cfg_ff <= is_cfg_cell;
      lat_idx_ff <= acc_idx;
      lat_data_ff <= pwdata[7:0];
    end
  end

  // one program or erase per rise of the voltage enable
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      apply_ff <= 1'b0;
    else
      apply_ff <= volt_ff == 1'b0 && wr_acc &&
        paddr == eeprom_ctrl_pkg::OFF_PROG &&
        pwdata[eeprom_ctrl_pkg::PROG_VOLT] &&
        pwdata[eeprom_ctrl_pkg::PROG_LATCH] && latch_ff &&
        seq_ff == eeprom_ctrl_pkg::SEQ_LOADED &&
        !blocked(block_protect_reg_ff, lat_cfg_ff, lat_idx_ff);
  end

  nv_cell_array #(
    .DEPTH(DEPTH),
    .AW(AW)
  ) u_cells (
    .clk(pclk),
    .rst_n(presetn),
    .rd_idx(acc_idx),
    .rd_data(arr_rd),
    .wr_en(apply_ff && !lat_cfg_ff),
    .erase(erase_ff),
    .wr_idx(lat_idx_ff),
    .wr_data(lat_data_ff)
  );

  // config cell behaves like any other nonvolatile byte
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cfg_ff <= eeprom_ctrl_pkg::CFG_RESET;
    else if (apply_ff && lat_cfg_ff)
    begin
      if (erase_ff)
        cfg_ff <= eeprom_ctrl_pkg::ERASED_BYTE;
      else
        cfg_ff <= cfg_ff & lat_data_ff;
    end
  end

  // cycles since reset release; saturates at the window limit
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cnt_ff <= '0;
    else if (window_open)
      cnt_ff <= cnt_ff + CW'(1);
  end

  always_comb
  begin
    if (special_mode_flag_ff)
      nxt_block_protect_reg = w_bp;
    else if (window_open && !bp_written_ff)
      nxt_block_protect_reg = w_bp;
    else
      nxt_block_protect_reg = block_protect_reg_ff | w_bp;
  end

  // block protect register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      block_protect_reg_ff <= '1;
      bp_written_ff <= 1'b0;
    end
    else if (wr_acc && paddr == eeprom_ctrl_pkg::OFF_BLOCK_PROTECT_REG)
    begin
      block_protect_reg_ff <= nxt_block_protect_reg;
      bp_written_ff <= !special_mode_flag_ff;
    end
  end

  // pump clock select
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pump_sel_ff <= 1'b0;
    else if (wr_acc && paddr == eeprom_ctrl_pkg::OFF_OPTION)
      pump_sel_ff <= pwdata[eeprom_ctrl_pkg::OPT_PUMP_SEL];
  end

  // mode flags: caught on the first edge after release, then writable
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      captured_ff <= 1'b0;
      special_mode_flag_ff <= 1'b0;
      mda_ff <= 1'b0;
      mda_written_ff <= 1'b0;
    end
    else if (!captured_ff)
    begin
      captured_ff <= 1'b1;
      special_mode_flag_ff <= !mode_pin_b;
      mda_ff <= mode_pin_a;
    end
    else if (wr_acc && paddr == eeprom_ctrl_pkg::OFF_MODE)
    begin
      special_mode_flag_ff <= special_mode_flag_ff & pwdata[eeprom_ctrl_pkg::MODE_SPECIAL];
      if (special_mode_flag_ff || !mda_written_ff)
        mda_ff <= pwdata[eeprom_ctrl_pkg::MODE_SEL_A];
      if (!special_mode_flag_ff)
        mda_written_ff <= 1'b1;
    end
  end

  // read data captured during the setup cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_ff <= '0;
    else if (rd_setup)
    begin
      prdata_ff <= '0;
      case (paddr)
        eeprom_ctrl_pkg::OFF_PROG:
        begin
          prdata_ff[eeprom_ctrl_pkg::PROG_VOLT] <= volt_ff;
          prdata_ff[eeprom_ctrl_pkg::PROG_LATCH] <= latch_ff;
          prdata_ff[eeprom_ctrl_pkg::PROG_ERASE] <= erase_ff;
        end
        eeprom_ctrl_pkg::OFF_BLOCK_PROTECT_REG:
          prdata_ff[BP_W-1:0] <= block_protect_reg_ff;
        eeprom_ctrl_pkg::OFF_OPTION:
          prdata_ff[eeprom_ctrl_pkg::OPT_PUMP_SEL] <= pump_sel_ff;
        eeprom_ctrl_pkg::OFF_CONFIG,
        eeprom_ctrl_pkg::CFG_CELL_ADDR:
          prdata_ff[7:0] <= cfg_ff;
        eeprom_ctrl_pkg::OFF_MODE:
        begin
          prdata_ff[eeprom_ctrl_pkg::MODE_SEL_A] <= mda_ff;
          prdata_ff[eeprom_ctrl_pkg::MODE_SPECIAL] <= special_mode_flag_ff;
        end
        eeprom_ctrl_pkg::OFF_STATUS:
        begin
          prdata_ff[eeprom_ctrl_pkg::STAT_WINDOW] <= window_open;
          prdata_ff[eeprom_ctrl_pkg::STAT_VOLT] <= volt_ff;
          prdata_ff[eeprom_ctrl_pkg::STAT_LOADED] <=
            seq_ff == eeprom_ctrl_pkg::SEQ_LOADED;
        end
        default:
        begin
          // cells are only readable as rom outside latch mode
          if (in_array && !latch_ff)
            prdata_ff[7:0] <= arr_rd;
        end
      endcase
    end
  end
  assign prdata = prdata_ff;
  // gated mux; only runs while high voltage is requested
  assign pump_clk = volt_ff && (pump_sel_ff ? rc_osc_clk : pclk);
  assign vpp_enable = volt_ff;
  assign special_mode_flag = special_mode_flag_ff;
  assign mode_select_a_flag = mda_ff;
  assign array_visible_enable = cfg_ff[eeprom_ctrl_pkg::CFG_VISIBLE];

endmodule // eeprom_program_protect_ctrl
`default_nettype wire

// ### hw/nv_cell_array.sv
// flip-flop model of the nonvolatile byte array
// assumes the controller issues at most one program or erase per cycle
`timescale 1ns/1ps
`default_nettype none
module nv_cell_array #(
  parameter int DEPTH = 512,
  parameter int AW = 9
)(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // read port
  input wire logic [AW-1:0] rd_idx,
  output logic [7:0] rd_data,
  // program port
  input wire logic wr_en,
  input wire logic erase,
  input wire logic [AW-1:0] wr_idx,
  input wire logic [7:0] wr_data
);

  logic [7:0] cell_ff [DEPTH];

  // the index must reach every byte
  if (DEPTH < 2 || (1 << AW) < DEPTH)
    $error("AW too narrow for DEPTH");

  genvar i;
  generate
    for (i = 0; i < DEPTH; i++)
    begin : g_cell
      // reset stands for a blank part; contents otherwise survive
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
          cell_ff[i] <= eeprom_ctrl_pkg::ERASED_BYTE;
        else if (wr_en && wr_idx == AW'(i))
        begin
          if (erase)
            cell_ff[i] <= eeprom_ctrl_pkg::ERASED_BYTE;
          else
            cell_ff[i] <= cell_ff[i] & wr_data;
        end
      end
    end
  endgenerate

  assign rd_data = cell_ff[rd_idx];

endmodule // nv_cell_array
`default_nettype wire

// ### sim/eeprom_ctrl_monitor.sv
// port-level checker for the program and protect block
// assumes zero-wait apb and the package register offsets
`timescale 1ns/1ps
`default_nettype none
module eeprom_ctrl_monitor (
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [12:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  // pins
  input wire logic mode_pin_b,
  input wire logic rc_osc_clk,
  input wire logic pump_clk,
  input wire logic vpp_enable,
  input wire logic special_mode_flag,
  input wire logic array_visible_enable
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic lat_ff;
  logic sel_ff;
  wire logic acc = psel && penable;
  wire logic prog_wr = acc && pwrite && paddr == eeprom_ctrl_pkg::OFF_PROG;
  wire logic arm = prog_wr && pwdata[1:0] == 2'b11 && lat_ff;
  // shadow of the latch bit, so a combined first write can be judged
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lat_ff <= 1'b0;
      sel_ff <= 1'b0;
    end
    else
    begin
      if (prog_wr)
        lat_ff <= pwdata[1] && (!pwdata[0] || lat_ff);
      if (acc && pwrite && paddr == eeprom_ctrl_pkg::OFF_OPTION)
        sel_ff <= pwdata[0];
    end
  end
  AST_PREADY: assert property (acc |-> pready)
    else $error("pready low in access phase");
  AST_SETUP_NOERR: assert property (psel && !penable |-> !pslverr)
    else $error("error flagged in setup phase");
  AST_UNMAPPED: assert property (acc && paddr == 13'h001C |-> pslverr)
    else $error("unmapped access not refused");
  AST_HIDDEN: assert property (acc && !array_visible_enable &&
    paddr >= eeprom_ctrl_pkg::ARRAY_BASE |-> pslverr)
    else $error("hidden array access not refused");
  AST_BOTH_SET: assert property (prog_wr && pwdata[1:0] == 2'b11 &&
    !lat_ff |=> !vpp_enable [*2])
    else $error("voltage on after combined write");
  AST_VPP_CAUSE: assert property ($rose(vpp_enable) |-> $past(arm))
    else $error("voltage on without ordered writes");
  AST_VPP_OFF: assert property (prog_wr && !pwdata[0] |=> !vpp_enable)
    else $error("voltage stayed on");
  AST_PUMP_IDLE: assert property (!vpp_enable |-> !pump_clk)
    else $error("pump clock runs without voltage");
  AST_PUMP_RC: assert property (vpp_enable && sel_ff |->
    pump_clk == rc_osc_clk)
    else $error("pump not on rc clock");
  AST_MODE_LOAD: assert property ($rose(presetn) |=>
    special_mode_flag == !$past(mode_pin_b))
    else $error("special flag not loaded from pin");
  AST_SPECIAL_STICKY: assert property (!special_mode_flag &&
    !$rose(presetn) |=> !special_mode_flag)
    else $error("special flag set again");
  COV_VPP: cover property ($rose(vpp_enable));
  COV_ERR: cover property (acc && pslverr);
  COV_SPECIAL: cover property (special_mode_flag);
endmodule // eeprom_ctrl_monitor
bind eeprom_program_protect_ctrl eeprom_ctrl_monitor mon (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .mode_pin_b(mode_pin_b), .rc_osc_clk(rc_osc_clk),
  .pump_clk(pump_clk), .vpp_enable(vpp_enable),
  .special_mode_flag(special_mode_flag),
  .array_visible_enable(array_visible_enable)
);
`default_nettype wire

// ### sim/tb_top.sv
// self-checking bench for the program and protect block
// assumes DEPTH 16, so four sections of four bytes each
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  typedef struct packed {logic rd; logic err; logic [31:0] d;} exp_t;
  localparam logic [12:0] A5 = eeprom_ctrl_pkg::ARRAY_BASE + 13'h0014;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [12:0] paddr = 13'h0000;
  logic [31:0] pwdata = 32'h00000000;
  logic mode_pin_a = 1'b1;
  logic mode_pin_b = 1'b1;
  logic rc_osc_clk = 1'b0;
  wire [31:0] prdata;
  wire pready, pslverr, pump_clk, vpp, spec, sela, vis;
  int bad_count = 0;
  int n_tests = 0;
  logic [31:0] seed = 32'h00001EFD;
  logic [7:0] rb;
  exp_t expq[$];
  exp_t cur;
  always #12.5 pclk = ~pclk;
  // rc clock kept off the pclk grid so mux samples never race
  always #17.3 rc_osc_clk = ~rc_osc_clk;
  eeprom_program_protect_ctrl #(.DEPTH(16), .NUM_SECT(4)) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .mode_pin_a(mode_pin_a),
    .mode_pin_b(mode_pin_b), .rc_osc_clk(rc_osc_clk), .pump_clk(pump_clk),
    .vpp_enable(vpp), .special_mode_flag(spec), .mode_select_a_flag(sela),
    .array_visible_enable(vis));
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cb(input string nm, input logic e, input logic g);
    chk(nm, {31'h0, e}, {31'h0, g});
  endtask
  task automatic apb(input logic w, input logic [12:0] a,
    input logic [31:0] d, input logic [31:0] ed, input logic ee);
    expq.push_back('{rd: !w, err: ee, d: ed});
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // only the watchdog ends a wait for pready
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [12:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 32'h0, 1'b0);
  endtask
  task automatic rd(input logic [12:0] a, input logic [31:0] e,
    input logic ee);
    apb(1'b0, a, 32'h0, e, ee);
  endtask
  task automatic prog(input logic [12:0] a, input logic [7:0] d,
    input logic er);
    wr(eeprom_ctrl_pkg::OFF_PROG, {29'h0, er, 2'b10});
    wr(a, {24'h0, d});
    wr(eeprom_ctrl_pkg::OFF_PROG, {29'h0, er, 2'b11});
    repeat (3) @(posedge pclk);
    wr(eeprom_ctrl_pkg::OFF_PROG, 32'h0);
  endtask
  task automatic do_reset(input logic b, input logic a);
    @(posedge pclk);
    presetn <= 1'b0;
    mode_pin_b <= b;
    mode_pin_a <= a;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    #1;
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  always @(posedge pclk)
  begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 &&
      expq.size() > 0)
    begin
      cur = expq.pop_front();
      chk("pslverr", {31'h0, cur.err}, {31'h0, pslverr});
      if (cur.rd && !cur.err)
        chk("prdata", cur.d, prdata);
    end
  end
  initial
  begin
    #(25 * 4000);
    bad_count++;
    results();
  end
  initial
  begin
    do_reset(1'b1, 1'b1);
    cb("special", 1'b0, spec);
    cb("sel a", 1'b1, sela);
    rd(eeprom_ctrl_pkg::OFF_BLOCK_PROTECT_REG, 32'h1F, 1'b0);
    rd(eeprom_ctrl_pkg::OFF_CONFIG, 32'hFF, 1'b0);
    wr(eeprom_ctrl_pkg::OFF_BLOCK_PROTECT_REG, 32'h0);
    rd(eeprom_ctrl_pkg::OFF_BLOCK_PROTECT_REG, 32'h0, 1'b0);
    wr(eeprom_ctrl_pkg::OFF_OPTION, 32'h1);
    rb = 8'(xs());
    prog(A5, rb, 1'b0);
    rd(A5, {24'h0, rb}, 1'b0);
    prog(A5, 8'hFF, 1'b0);
    rd(A5, {24'h0, rb}, 1'b0);
    $display("program test done");
    wr(eeprom_ctrl_pkg::OFF_PROG, 32'h3);
    #1 cb("vpp", 1'b0, vpp);
    rd(eeprom_ctrl_pkg::OFF_PROG, 32'h0, 1'b0);
    wr(eeprom_ctrl_pkg::OFF_OPTION, 32'h0);
    prog(A5, 8'h00, 1'b1);
    rd(A5, 32'hFF, 1'b0);
    wr(eeprom_ctrl_pkg::OFF_BLOCK_PROTECT_REG, 32'h2);
    rd(eeprom_ctrl_pkg::OFF_BLOCK_PROTECT_REG, 32'h2, 1'b0);
    prog(A5, 8'h00, 1'b0);
    rd(A5, 32'hFF, 1'b0);
    $display("protect test done");
    repeat (70) @(posedge pclk);
    wr(eeprom_ctrl_pkg::OFF_BLOCK_PROTECT_REG, 32'h0);
    rd(eeprom_ctrl_pkg::OFF_BLOCK_PROTECT_REG, 32'h2, 1'b0);
    rd(13'h001C, 32'h0, 1'b1);
    prog(eeprom_ctrl_pkg::CFG_CELL_ADDR, 8'hFE, 1'b0);
    #1 cb("visible", 1'b0, vis);
    rd(A5, 32'h0, 1'b1);
    wr(eeprom_ctrl_pkg::OFF_MODE, 32'h0);
    wr(eeprom_ctrl_pkg::OFF_MODE, 32'h3);
    #1 cb("sel a", 1'b0, sela);
    cb("special", 1'b0, spec);
    $display("normal mode test done");
    do_reset(1'b0, 1'b0);
    cb("special", 1'b1, spec);
    cb("sel a", 1'b0, sela);
    rd(eeprom_ctrl_pkg::OFF_BLOCK_PROTECT_REG, 32'h1F, 1'b0);
    repeat (70) @(posedge pclk);
    for (int k = 0; k < 3; k++)
    begin
      wr(eeprom_ctrl_pkg::OFF_BLOCK_PROTECT_REG, k[0] ? 32'h1F : 32'h0);
      rd(eeprom_ctrl_pkg::OFF_BLOCK_PROTECT_REG, k[0] ? 32'h1F : 32'h0, 1'b0);
    end
    wr(eeprom_ctrl_pkg::OFF_MODE, 32'h1);
    #1 cb("sel a", 1'b1, sela);
    cb("special", 1'b0, spec);
    // special flag now clear: the next write is the one normal-mode write
    wr(eeprom_ctrl_pkg::OFF_MODE, 32'h3);
    wr(eeprom_ctrl_pkg::OFF_MODE, 32'h2);
    #1 cb("sel a", 1'b1, sela);
    cb("special", 1'b0, spec);
    $display("special mode test done");
    do_reset(1'b1, 1'b0);
    cb("sel a", 1'b0, sela);
    rd(eeprom_ctrl_pkg::OFF_STATUS, 32'h1, 1'b0);
    repeat (70) @(posedge pclk);
    rd(eeprom_ctrl_pkg::OFF_STATUS, 32'h0, 1'b0);
    wr(eeprom_ctrl_pkg::OFF_BLOCK_PROTECT_REG, 32'h0);
    rd(eeprom_ctrl_pkg::OFF_BLOCK_PROTECT_REG, 32'h1F, 1'b0);
    $display("window test done");
    results();
  end
endmodule // tb_top
`default_nettype wire
